// ===== design/mbfc_pkg.sv
// shared constants and types for the frame checker
package mbfc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_S = 1000000000;
  localparam int ASCII_GAP_S = 1;
  localparam int ASCII_GAP_CYCLES = (ASCII_GAP_S * NS_PER_S) / CLK_PERIOD_NS;
  localparam int BAUD_RATE = 9600;
  localparam int BIT_CYCLES = NS_PER_S / (CLK_PERIOD_NS * BAUD_RATE);
  localparam int RTU_GAP_BITS = 24;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_LEVEL_W = 4;
  localparam logic [3:0] FIFO_READY_LIMIT = 4'h6;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [16:0] REF_OFFSET = 17'h09c41;
  localparam logic [6:0] CHAR_COLON = 7'h3a;
  localparam logic [6:0] CHAR_CR = 7'h0d;
  localparam logic [6:0] CHAR_LF = 7'h0a;
  localparam logic [7:0] REF_HI_INDEX = 8'h02;
  localparam logic [7:0] REF_LO_INDEX = 8'h03;

  // one decoded message byte on its way out
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } mbfc_byte_t;

  // outcome of one finished frame
  typedef struct packed {
    logic ok;
    logic [15:0] check;
  } mbfc_result_t;

  typedef enum logic [1:0] {
    MBFC_IDLE = 2'b00,
    MBFC_HI = 2'b01,
    MBFC_LO = 2'b10,
    MBFC_LF = 2'b11
  } mbfc_ascii_st_t;
endpackage

// ===== design/mbfc_fifo.sv
// small fifo with registered read data
`timescale 1ns/1ns
`default_nettype none
module mbfc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  wire push = in_valid && in_ready;
  wire pop = (level != '0) && (!out_valid || out_ready);

  // full when every slot is taken
  assign in_ready = level != (AW+1)'(DEPTH);

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // pointers, level and output stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      level <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
        out_data <= mem[rp];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // mbfc_fifo
`default_nettype wire

// ===== design/mbfc_check.sv
// Contract
// - address field carries reference minus 40001; device adds 40001 back
// - ascii check covers address through last data, not colon, cr, lf
// - ascii check is two's complement of the 8-bit sum, carry dropped
// - ascii bytes travel as two hex characters; sum over decoded bytes
// - rtu crc is 16-bit remainder over data bits, address through last data
// - crc starts at all ones each message, first byte xored in
// - low byte of xor result indexes 256-entry a001 table
// - high byte shifted low, xored with table entry, gives new crc
// - new crc seeds next byte; repeat through final data byte
// - crc appended low byte first, high byte last
// - ascii frame opens with colon, closes cr lf; rtu has no marks
// - ascii gaps at most one second; rtu frame ends after 24 bit-time gap
`timescale 1ns/1ns
`default_nettype none
module mbfc_check #(
  parameter int ASCII_GAP_CYCLES = mbfc_pkg::ASCII_GAP_CYCLES,
  parameter int BIT_CYCLES = mbfc_pkg::BIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ascii_mode,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output mbfc_pkg::mbfc_byte_t out_byte,
  output logic frame_done,
  output mbfc_pkg::mbfc_result_t frame_result,
  output logic ref_valid,
  output logic [16:0] ref_number
);
  // table entry built by the reflected bit-serial shifter
  function automatic logic [15:0] crc_table(input logic [7:0] idx);
    logic [15:0] r;
    r = {8'h00, idx};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mbfc_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ascii hex character to nibble
  function automatic logic [4:0] hex_val(input logic [6:0] c);
    logic [4:0] v;
    v = 5'h10;
    if (c >= 7'h30 && c <= 7'h39) begin
      v = {1'b0, 4'(c - 7'h30)};
    end else if (c >= 7'h41 && c <= 7'h46) begin
      v = {1'b0, 4'(c - 7'h37)};
    end else if (c >= 7'h61 && c <= 7'h66) begin
      v = {1'b0, 4'(c - 7'h57)};
    end
    return v;
  endfunction

  logic rst_s1;
  logic rst_n;
  mbfc_pkg::mbfc_ascii_st_t st;
  logic in_frame;
  logic [3:0] hi_nib;
  logic [15:0] crc;
  logic [15:0] crc_d1;
  logic [15:0] crc_d2;
  logic [7:0] sum;
  logic [7:0] sum_d1;
  logic [7:0] byte_d1;
  logic [7:0] byte_d2;
  logic [7:0] count;
  logic [7:0] ref_hi;
  logic [31:0] idle_cycles;
  logic [31:0] bit_div;
  logic [7:0] gap_bits;
  logic [3:0] fifo_level;

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // input character decode
  wire take = in_valid && in_ready;
  wire [6:0] chr = in_data[6:0];
  wire [4:0] nib = hex_val(chr);
  wire is_colon = chr == mbfc_pkg::CHAR_COLON;
  wire is_cr = chr == mbfc_pkg::CHAR_CR;
  wire is_lf = chr == mbfc_pkg::CHAR_LF;
  wire is_hex = !nib[4];

  // a binary byte is formed: raw in rtu, second hex digit in ascii
  wire lo_digit = st == mbfc_pkg::MBFC_LO && is_hex;
  wire a_byte = take && ascii_mode && lo_digit;
  wire r_byte = take && !ascii_mode;
  wire byte_stb = a_byte || r_byte;
  wire [7:0] byte_val = ascii_mode ? {hi_nib, nib[3:0]} : in_data;
  wire first = ascii_mode ? (count == 8'h00) : !in_frame;

  // crc step: seed, xor, lookup, combine
  wire [15:0] crc_in = first ? mbfc_pkg::CRC_SEED : crc;
  wire [15:0] crc_x = crc_in ^ {8'h00, byte_val};
  wire [15:0] crc_next = {8'h00, crc_x[15:8]} ^ crc_table(crc_x[7:0]);
  wire [7:0] sum_in = first ? 8'h00 : sum;
  wire [7:0] sum_next = 8'(sum_in + byte_val);

  // one tick per rtu bit time
  wire bit_tick = bit_div == 32'(BIT_CYCLES - 1);

  // rtu frame ends once the line stays silent past the gap limit
  wire rtu_silent = gap_bits == 8'(mbfc_pkg::RTU_GAP_BITS);
  wire rtu_end = !ascii_mode && in_frame && bit_tick && rtu_silent;

  // ascii frame ends on the line feed after the carriage return
  wire ascii_end = take && ascii_mode && st == mbfc_pkg::MBFC_LF && is_lf;

  // ascii abort causes; any of them ends the frame with a bad verdict unless the closing line feed is taken in that cycle
  wire in_ascii_frame = ascii_mode && st != mbfc_pkg::MBFC_IDLE;
  wire lf_missing = st == mbfc_pkg::MBFC_LF && !is_lf;
  wire cr_at_end = st == mbfc_pkg::MBFC_HI && is_cr;
  wire char_bad = st != mbfc_pkg::MBFC_LF && !is_hex && !cr_at_end;
  wire char_abort = take && !is_colon && (lf_missing || char_bad);
  wire gap_abort = idle_cycles >= 32'(ASCII_GAP_CYCLES);
  wire ascii_bad = in_ascii_frame && (char_abort || gap_abort);

  // any frame end, good or bad
  wire frame_end = rtu_end || ascii_end || ascii_bad;

  // ascii: the sum over payload and check byte comes to zero
  wire [7:0] lrc_calc = 8'(8'h00 - sum_d1);
  wire lrc_ok = count >= 8'h02 && sum == 8'h00;

  // rtu check field arrives low byte first, so the last byte is the high one
  wire [15:0] rx_check = {byte_d1, byte_d2};
  wire crc_ok = count >= 8'h03 && crc_d2 == rx_check;

  // verdict and reported check for the current mode
  wire end_ok = ascii_mode ? lrc_ok : crc_ok;
  wire [15:0] end_check = ascii_mode ? {8'h00, lrc_calc} : crc_d2;

  // ascii character sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= mbfc_pkg::MBFC_IDLE;
      hi_nib <= 4'h0;
    end else if (!ascii_mode || ascii_bad || ascii_end) begin
      st <= mbfc_pkg::MBFC_IDLE;
    end else if (take) begin
      case (st)
        mbfc_pkg::MBFC_IDLE: begin
          if (is_colon) begin
            st <= mbfc_pkg::MBFC_HI;
          end
        end
        mbfc_pkg::MBFC_HI: begin
          if (is_colon) begin
            st <= mbfc_pkg::MBFC_HI;
          end else if (is_cr) begin
            st <= mbfc_pkg::MBFC_LF;
          end else begin
            hi_nib <= nib[3:0];
            st <= mbfc_pkg::MBFC_LO;
          end
        end
        mbfc_pkg::MBFC_LO: begin
          // second digit closes the byte; a colon restarts the frame
          st <= mbfc_pkg::MBFC_HI;
        end
        default: st <= mbfc_pkg::MBFC_IDLE;
      endcase
    end
  end

  // ascii idle counter, cleared by each character and outside frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cycles <= '0;
    end else begin
      idle_cycles <= (take || st == mbfc_pkg::MBFC_IDLE) ? '0 : idle_cycles + 1'b1;
    end
  end

  // rtu bit-time divider and count of silent bit times
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_div <= '0;
      gap_bits <= 8'h00;
    end else begin
      bit_div <= (r_byte || bit_tick) ? '0 : bit_div + 1'b1;
      if (r_byte) begin
        gap_bits <= 8'h00;
      end else if (bit_tick && gap_bits != 8'hff) begin
        gap_bits <= gap_bits + 1'b1;
      end
    end
  end

  // check accumulators and byte history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= mbfc_pkg::CRC_SEED;
      crc_d1 <= mbfc_pkg::CRC_SEED;
      crc_d2 <= mbfc_pkg::CRC_SEED;
      sum <= 8'h00;
      sum_d1 <= 8'h00;
      byte_d1 <= 8'h00;
      byte_d2 <= 8'h00;
    end else if (byte_stb) begin
      crc <= crc_next;
      crc_d1 <= crc_in;
      crc_d2 <= first ? mbfc_pkg::CRC_SEED : crc_d1;
      sum <= sum_next;
      sum_d1 <= sum_in;
      byte_d1 <= byte_val;
      byte_d2 <= first ? 8'h00 : byte_d1;
    end
  end

  // position inside the frame; cleared at every frame end or restart that takes no byte in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame <= 1'b0;
      count <= 8'h00;
    end else if (byte_stb) begin
      in_frame <= 1'b1;
      count <= first ? 8'h01 : (count == 8'hff ? count : count + 1'b1);
    end else if (frame_end || (take && is_colon)) begin
      in_frame <= 1'b0;
      count <= 8'h00; // next colon or rtu byte reseeds
    end
  end

  // register reference field: bytes two and three of every frame
  wire ref_hi_hit = byte_stb && !first && count == mbfc_pkg::REF_HI_INDEX;
  wire ref_lo_hit = byte_stb && !first && count == mbfc_pkg::REF_LO_INDEX;
  wire [16:0] ref_decoded = {1'b0, ref_hi, byte_val} + mbfc_pkg::REF_OFFSET;

  // frame outcome, held until the next frame end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_done <= 1'b0;
      frame_result <= '0;
    end else begin
      frame_done <= frame_end;
      if (rtu_end || ascii_end) begin
        frame_result <= '{ok: end_ok, check: end_check};
      end else if (ascii_bad) begin
        frame_result <= '{ok: 1'b0, check: 16'h0000};
      end
    end
  end

  // decoded register reference, offset added back to the address field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_valid <= 1'b0;
      ref_hi <= 8'h00;
      ref_number <= 17'h00000;
    end else begin
      ref_valid <= ref_lo_hit;
      if (ref_hi_hit) begin
        ref_hi <= byte_val;
      end
      if (ref_lo_hit) begin
        ref_number <= ref_decoded;
      end
    end
  end

  // room test: the flag is a cycle late, so one more push may still land
  wire fifo_room = fifo_level < mbfc_pkg::FIFO_READY_LIMIT;

  // input ready leaves room for a push already in flight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= fifo_room;
    end
  end

  // decoded bytes buffered toward the consumer
  mbfc_fifo #(
    .WIDTH($bits(mbfc_pkg::mbfc_byte_t)),
    .DEPTH(mbfc_pkg::FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(byte_stb),
    .in_ready(),
    .in_data({first, byte_val}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_byte),
    .level(fifo_level)
  );
endmodule // mbfc_check
`default_nettype wire

// ===== verif/mbfc_check_sva.sv
// port assertions for the frame checker
`timescale 1ns/1ns
`default_nettype none
module mbfc_check_sva #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ascii_mode,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire mbfc_pkg::mbfc_byte_t out_byte,
  input wire logic frame_done,
  input wire mbfc_pkg::mbfc_result_t frame_result,
  input wire logic ref_valid,
  input wire logic [16:0] ref_number
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] idle_cnt;
  // cycles since the last accepted character
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) idle_cnt <= '0;
    else if (in_valid && in_ready) idle_cnt <= '0;
    else if (idle_cnt != 16'hffff) idle_cnt <= idle_cnt + 16'h0001;
  end
  a_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("frame done too long");
  a_ref_pulse: assert property (ref_valid |=> !ref_valid)
    else $error("ref valid too long");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("out byte not held");
  a_result_hold: assert property ($changed(frame_result) |-> frame_done)
    else $error("result moved without done");
  a_ref_hold: assert property ($changed(ref_number) |-> ref_valid)
    else $error("ref moved without valid");
  a_ref_offset: assert property (ref_valid |-> ref_number >= 17'd40001)
    else $error("ref offset missing");
  a_ascii_end: assert property (frame_done && ascii_mode && frame_result.ok |->
    $past(in_valid && in_ready && in_data[6:0] == 7'h0a))
    else $error("ascii frame ended without line feed");
  a_rtu_gap: assert property (frame_done && !ascii_mode |-> idle_cnt >= 16'(24 * BIT_CYCLES))
    else $error("rtu frame ended early");
endmodule // mbfc_check_sva
bind mbfc_check mbfc_check_sva #(.BIT_CYCLES(BIT_CYCLES)) u_sva (.clk(clk),
  .reset_n(reset_n), .ascii_mode(ascii_mode), .in_valid(in_valid), .in_ready(in_ready),
  .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte),
  .frame_done(frame_done), .frame_result(frame_result), .ref_valid(ref_valid),
  .ref_number(ref_number));
`default_nettype wire

// ===== verif/mbfc_host.sv
// master-side model feeding received characters
`timescale 1ns/1ns
`default_nettype none
module mbfc_host (
  input wire logic clk,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data
);
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
  end
  // hold a character until taken, short random pauses between
  task automatic send(input logic [7:0] b);
    if ($urandom % 4 == 0) begin
      in_valid <= 1'b0;
      in_data <= ~b;
      @(posedge clk);
    end
    in_valid <= 1'b1;
    in_data <= b;
    do @(posedge clk); while (in_ready !== 1'b1);
  endtask
  // drop the request, data line shows junk
  task automatic release_bus();
    in_valid <= 1'b0;
    in_data <= ~in_data;
  endtask
endmodule // mbfc_host
`default_nettype wire

// ===== verif/modbus_frame_check_test.sv
// random and corner frames through the frame checker
`timescale 1ns/1ns
`default_nettype none
module modbus_frame_check_test;
  logic clk = 1'b0, reset_n = 1'b0, ascii_mode = 1'b0, out_ready = 1'b0, hold = 1'b1;
  logic in_valid, in_ready, out_valid, frame_done, ref_valid;
  logic [7:0] in_data;
  logic [16:0] ref_number;
  mbfc_pkg::mbfc_byte_t out_byte;
  mbfc_pkg::mbfc_result_t frame_result;
  int fail_count = 0, n_tests = 0, cyc = 0;
  logic [16:0] eb[$], er[$], ef[$];
  always #5 clk = ~clk;
  mbfc_host host (.clk(clk), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));
  mbfc_check #(.ASCII_GAP_CYCLES(200), .BIT_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n),
    .ascii_mode(ascii_mode), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte),
    .frame_done(frame_done), .frame_result(frame_result), .ref_valid(ref_valid),
    .ref_number(ref_number));
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bit-serial reference crc, lsb first
  function automatic logic [15:0] crc16(input logic [7:0] d[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (d[i]) begin
      c ^= {8'h00, d[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [7:0] hx(input logic [3:0] n, input logic lc);
    return n < 4'ha ? 8'h30 + {4'h0, n} : (lc ? 8'h57 : 8'h37) + {4'h0, n};
  endfunction
  // reference number: digit 4 takes the place of the register letter
  function automatic logic [16:0] ref_of(input int word);
    return 17'(40000 + word);
  endfunction
  // build one frame, queue expectations, send it
  task automatic frame(input logic [7:0] pl[$], input bit asc, input bit bad);
    logic [7:0] f[$];
    logic [15:0] c;
    logic [7:0] s;
    f = pl;
    c = crc16(pl);
    s = 8'h00;
    foreach (pl[i]) s += pl[i];
    s = -s;
    if (asc) f.push_back(s ^ {7'h00, bad});
    else f = {f, c[7:0] ^ {7'h00, bad}, c[15:8]};
    foreach (f[i]) eb.push_back({8'h00, i == 0, f[i]});
    er.push_back({!bad, asc ? {8'h00, s} : c});
    ef.push_back({1'b0, pl[2], pl[3]} + 17'd40001);
    ascii_mode <= asc;
    @(posedge clk);
    if (asc) host.send(8'h3a);
    foreach (f[i]) begin
      if (asc) begin
        host.send(hx(f[i][7:4], i[0]));
        host.send(hx(f[i][3:0], i[0]));
      end else host.send(f[i]);
    end
    if (asc) host.send(8'h0d);
    if (asc) host.send(8'h0a);
    host.release_bus();
    repeat (140) @(posedge clk);
  endtask
  // consumer with random stalls, monitors, timeout
  always @(posedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      fail_count++;
      test_done();
    end
    out_ready <= !hold && ($urandom % 3 != 0);
    if (reset_n && out_valid && out_ready)
      chk({8'h00, out_byte}, eb.size() ? eb.pop_front() : 17'h1ffff);
    if (reset_n && frame_done)
      chk({frame_result.ok, ascii_mode ? 8'h00 : frame_result.check[15:8],
        frame_result.check[7:0]}, er.size() ? er.pop_front() : 17'h1ffff);
    if (reset_n && ref_valid)
      chk(ref_number, ef.size() ? ef.pop_front() : 17'h1ffff);
  end
  initial begin
    logic [7:0] p[$];
    void'($urandom(92414));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    fork
      frame({8'h0b, 8'h03, 8'h00, 8'h2a, 8'h00, 8'h04}, 1'b0, 1'b0);
      begin
        repeat (40) @(posedge clk);
        hold <= 1'b0;
      end
    join
    frame({8'h11, 8'h03, 8'h00, 8'hc8, 8'h00, 8'h04}, 1'b1, 1'b0);
    frame({8'hff, 8'hff, 8'hff, 8'hff}, 1'b0, 1'b0);
    frame({8'h01, 8'h03, 8'h00, 8'h64, 8'h00, 8'h01}, 1'b0, 1'b0);
    chk(ref_number, ref_of(101));
    // aborted ascii frames: a bad digit, then a line left silent
    er.push_back(17'h00000);
    er.push_back(17'h00000);
    ascii_mode <= 1'b1;
    @(posedge clk);
    host.send(8'h3a);
    host.send(8'h31);
    host.send(8'h47);
    host.send(8'h3a);
    host.send(8'h31);
    host.release_bus();
    repeat (260) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      p = {};
      repeat (4 + $urandom % 5) p.push_back(8'($urandom));
      frame(p, k[0], k[1]);
    end
    repeat (50) @(posedge clk);
    chk(17'(eb.size() + er.size() + ef.size()), 17'h00000);
    test_done();
  end
endmodule // modbus_frame_check_test
`default_nettype wire
